// File: hw/itc_pkg.sv
// Purpose: Shared constants for the paired interval timer capture block
// Assumes: 32-bit classic Wishbone, word aligned register map
// Notes: Offsets are byte addresses; narrower registers sit in low bits
package itc_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CMP_LOW = 8'h00;
	localparam logic [7:0] OFF_CMP_HIGH = 8'h04;
	localparam logic [7:0] OFF_CTL = 8'h08;
	localparam logic [7:0] OFF_DIV_LOW = 8'h0C;
	localparam logic [7:0] OFF_DIV_HIGH = 8'h10;
	localparam logic [7:0] OFF_CLK_SEL = 8'h14;
	localparam logic [7:0] OFF_CAP_CTL = 8'h18;
	localparam logic [7:0] OFF_CAP_RES = 8'h1C;
	localparam logic [7:0] OFF_STATUS = 8'h20;
	localparam logic [7:0] OFF_CNT_LOW = 8'h24;
	localparam logic [7:0] OFF_CNT_HIGH = 8'h28;
	localparam logic [7:0] OFF_SW_TRIG = 8'h2C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTL_RUN0 = 0;
	localparam int CTL_RUN1 = 1;
	localparam int CTL_RUN2 = 2;
	localparam int CTL_RUN3 = 3;
	localparam int CTL_MODE_LSB = 4;
	localparam int DIV_CH_A_LSB = 0;
	localparam int SEL_SRC_LSB = 0;
	localparam int SEL_CAP_LSB = 4;
	localparam int CC_EN = 0;
	localparam int CC_CLR = 1;
	localparam int CC_TRIG_LSB = 4;
	localparam int ST_CAP = 0;
	localparam int ST_OVR = 1;
	localparam int ST_LOW_MATCH = 2;
	localparam int SW_TRIG_BIT = 0;

	// ----------------------------------------------------------------
	// Encodings and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_CAPTURE = 2'h1;
	localparam logic [15:0] CMP_RESET = 16'hFFFF;
	localparam logic [7:0] REG8_RESET = 8'h00;
	localparam logic [15:0] CNT_RESET = 16'h0000;

	typedef enum logic [1:0] {
		TRIG_CMP_HIGH = 2'b00,
		TRIG_PIN = 2'b01,
		TRIG_SOFT = 2'b10
	} itc_trig_type;

endpackage

// File: hw/itc_tick_if.sv
// Purpose: Carries one-cycle edge ticks from the synchroniser
// Assumes: Single sys_clk domain on both sides
// Notes: Width covers all clock sources plus the trigger pin
`timescale 1ns/10ps
interface itc_tick_if #(parameter int W = 17);
	logic [W-1:0] tick;
	modport src (output tick);
	modport dst (input tick);
endinterface

// File: hw/itc_edge_sync.sv
// Purpose: Two-flop synchroniser and rising edge detector per input
// Assumes: Inputs toggle slower than half of sys_clk
// Notes: Faster sources alias; the count is then not trustworthy
`timescale 1ns/10ps
module itc_edge_sync #(
	parameter int W = 17
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [W-1:0] rawIn,
	itc_tick_if.src tickOut
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] last_q;

	// ----------------------------------------------------------------
	// Synchronise, then remember the settled level
	// ----------------------------------------------------------------
	// First stage feeds only the second stage
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			sync_q <= '0;
			last_q <= '0;
		end else begin
			meta_q <= rawIn;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	// One pulse per rising edge of each settled input
	assign tickOut.tick = sync_q & ~last_q;
endmodule

// File: hw/itc_capture16.sv
// Purpose: 16-bit capture mode of a paired-channel interval timer
// Assumes: Count and capture clocks arrive as pins slower than 20 MHz
// Notes: Registers on classic Wishbone, one-cycle registered ack
`timescale 1ns/10ps
module itc_capture16 #(
	parameter int NSRC = 8
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic wbCycI,
	input wire logic wbStbI,
	input wire logic wbWeI,
	input wire logic [7:0] wbAdrI,
	input wire logic [3:0] wbSelI,
	input wire logic [31:0] wbDatI,
	output logic [31:0] wbDatO,
	output logic wbAckO,
	input wire logic [NSRC-1:0] countClkIn,
	input wire logic [NSRC-1:0] capClkIn,
	input wire logic capTrigIn
);
	localparam int TW = 2 * NSRC + 1;

	logic [15:0] cmpLow_q, cmpHigh_q, capResult_q, cntLow_q, cntHigh_q;
	logic [7:0] ctl_q, divLow_q, divHigh_q, clkSel_q, capCtl_q;
	logic [6:0] pre_q;
	logic capFlag_q, ovrFlag_q, lowMatch_q, swTrig_q;
	logic busReq, busWr, modeCap, countTick, capTick, pinTick;
	logic lowStep, highStep, highMatch, trigHit, capFire, clearAfter;
	logic [2:0] srcSel, capSel, stClr;
	itc_pkg::itc_trig_type trigSel;
	logic [31:0] rdData;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Byte-lane merge for 16-bit registers
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [15:0] r;
		r = old;
		if (sel[0]) begin
			r[7:0] = nw[7:0];
		end
		if (sel[1]) begin
			r[15:8] = nw[15:8];
		end
		return r;
	endfunction

	// Mask of prescaler bits that must all be one to pass a tick
	function automatic logic [6:0] divMask(input logic [2:0] div);
		return 7'((8'h01 << div) - 8'h01);
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	itc_tick_if #(.W(TW)) tickBus ();

	itc_edge_sync #(.W(TW)) uSync (
		.sys_clk(sys_clk),
		.rst(rst),
		.rawIn({capTrigIn, capClkIn, countClkIn}),
		.tickOut(tickBus.src)
	);

	// ----------------------------------------------------------------
	// Decode of configuration fields
	// ----------------------------------------------------------------
	// Channel 1 and 3 enables and their dividers are kept but ignored
	assign modeCap = ctl_q[itc_pkg::CTL_MODE_LSB +: 2] ==
		itc_pkg::MODE_CAPTURE;
	assign srcSel = clkSel_q[itc_pkg::SEL_SRC_LSB +: 3];
	assign capSel = clkSel_q[itc_pkg::SEL_CAP_LSB +: 3];
	assign trigSel = itc_pkg::itc_trig_type'(
		capCtl_q[itc_pkg::CC_TRIG_LSB +: 2]);
	assign clearAfter = capCtl_q[itc_pkg::CC_CLR];
	assign countTick = tickBus.tick[srcSel];
	assign capTick = tickBus.tick[NSRC + 32'(capSel)];
	assign pinTick = tickBus.tick[TW-1];

	// Low pair steps on the divided count clock only
	assign lowStep = countTick && modeCap && ctl_q[itc_pkg::CTL_RUN0]
		&& ((pre_q & divMask(divLow_q[2:0])) ==
		divMask(divLow_q[2:0]));
	// High pair is never divided
	assign highStep = capTick && modeCap
		&& ctl_q[itc_pkg::CTL_RUN2];
	assign highMatch = highStep && cntHigh_q == cmpHigh_q;

	// ----------------------------------------------------------------
	// Trigger selection
	// ----------------------------------------------------------------
	always_comb begin
		unique case (trigSel)
			itc_pkg::TRIG_CMP_HIGH: trigHit = highMatch;
			itc_pkg::TRIG_PIN: trigHit = pinTick;
			itc_pkg::TRIG_SOFT: trigHit = swTrig_q;
			default: trigHit = 1'b0;
		endcase
	end

	assign capFire = trigHit && modeCap &&
		capCtl_q[itc_pkg::CC_EN];

	// ----------------------------------------------------------------
	// Prescaler for the low pair count clock
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pre_q <= '0;
		end else if (!ctl_q[itc_pkg::CTL_RUN0]) begin
			pre_q <= '0;
		end else if (countTick) begin
			pre_q <= pre_q + 7'h01;
		end
	end

	// ----------------------------------------------------------------
	// Counters
	// ----------------------------------------------------------------
	// Clear wins over a coincident step so the next tick counts one
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cntLow_q <= itc_pkg::CNT_RESET;
		end else if (capFire && clearAfter) begin
			cntLow_q <= itc_pkg::CNT_RESET;
		end else if (lowStep) begin
			if (cntLow_q == cmpLow_q) begin
				cntLow_q <= itc_pkg::CNT_RESET;
			end else begin
				cntLow_q <= cntLow_q + 16'h0001;
			end
		end
	end

	// Free-runs as a plain interval counter whatever the trigger is
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cntHigh_q <= itc_pkg::CNT_RESET;
		end else if (highMatch) begin
			cntHigh_q <= itc_pkg::CNT_RESET;
		end else if (highStep) begin
			cntHigh_q <= cntHigh_q + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Capture result
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			capResult_q <= itc_pkg::CNT_RESET;
		end else if (capFire) begin
			capResult_q <= cntLow_q;
		end
	end

	// ----------------------------------------------------------------
	// Sticky status flags, write one to clear, set wins
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			capFlag_q <= 1'b0;
			ovrFlag_q <= 1'b0;
			lowMatch_q <= 1'b0;
		end else begin
			if (capFire) begin
				capFlag_q <= 1'b1;
			end else if (stClr[itc_pkg::ST_CAP]) begin
				capFlag_q <= 1'b0;
			end
			// Unread result overwritten by a new capture
			if (capFire && capFlag_q) begin
				ovrFlag_q <= 1'b1;
			end else if (stClr[itc_pkg::ST_OVR]) begin
				ovrFlag_q <= 1'b0;
			end
			if (lowStep && cntLow_q == cmpLow_q) begin
				lowMatch_q <= 1'b1;
			end else if (stClr[itc_pkg::ST_LOW_MATCH]) begin
				lowMatch_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	assign busReq = wbCycI && wbStbI && !wbAckO;
	assign busWr = busReq && wbWeI;
	assign stClr = (busWr && wbAdrI == itc_pkg::OFF_STATUS && wbSelI[0]) ?
		wbDatI[2:0] : 3'h0; // Write one to clear, per status bit

	// Configuration writes
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cmpLow_q <= itc_pkg::CMP_RESET;
			cmpHigh_q <= itc_pkg::CMP_RESET;
			ctl_q <= itc_pkg::REG8_RESET;
			divLow_q <= itc_pkg::REG8_RESET;
			divHigh_q <= itc_pkg::REG8_RESET;
			clkSel_q <= itc_pkg::REG8_RESET;
			capCtl_q <= itc_pkg::REG8_RESET;
		end else if (busWr) begin
			unique case (wbAdrI)
				itc_pkg::OFF_CMP_LOW:
					cmpLow_q <= merge16(cmpLow_q, wbDatI, wbSelI);
				itc_pkg::OFF_CMP_HIGH:
					cmpHigh_q <= merge16(cmpHigh_q, wbDatI, wbSelI);
				itc_pkg::OFF_CTL:
					if (wbSelI[0]) ctl_q <= wbDatI[7:0];
				itc_pkg::OFF_DIV_LOW:
					if (wbSelI[0]) divLow_q <= wbDatI[7:0];
				itc_pkg::OFF_DIV_HIGH:
					if (wbSelI[0]) divHigh_q <= wbDatI[7:0];
				itc_pkg::OFF_CLK_SEL:
					if (wbSelI[0]) clkSel_q <= wbDatI[7:0];
				itc_pkg::OFF_CAP_CTL:
					if (wbSelI[0]) capCtl_q <= wbDatI[7:0];
				default: ;
			endcase
		end
	end

	// Software trigger is a one-cycle pulse after the write
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			swTrig_q <= 1'b0;
		end else begin
			swTrig_q <= busWr && wbAdrI == itc_pkg::OFF_SW_TRIG
				&& wbSelI[0] && wbDatI[itc_pkg::SW_TRIG_BIT];
		end
	end

	// Read mux; unmapped offsets read zero and still acknowledge
	always_comb begin
		rdData = '0;
		unique case (wbAdrI)
			itc_pkg::OFF_CMP_LOW: rdData[15:0] = cmpLow_q;
			itc_pkg::OFF_CMP_HIGH: rdData[15:0] = cmpHigh_q;
			itc_pkg::OFF_CTL: rdData[7:0] = ctl_q;
			itc_pkg::OFF_DIV_LOW: rdData[7:0] = divLow_q;
			itc_pkg::OFF_DIV_HIGH: rdData[7:0] = divHigh_q;
			itc_pkg::OFF_CLK_SEL: rdData[7:0] = clkSel_q;
			itc_pkg::OFF_CAP_CTL: rdData[7:0] = capCtl_q;
			itc_pkg::OFF_CAP_RES: rdData[15:0] = capResult_q;
			itc_pkg::OFF_STATUS: rdData[2:0] =
				{lowMatch_q, ovrFlag_q, capFlag_q};
			itc_pkg::OFF_CNT_LOW: rdData[15:0] = cntLow_q;
			itc_pkg::OFF_CNT_HIGH: rdData[15:0] = cntHigh_q;
			default: rdData = '0;
		endcase
	end

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wbAckO <= 1'b0;
			wbDatO <= '0;
		end else begin
			wbAckO <= busReq;
			if (busReq && !wbWeI) begin
				wbDatO <= rdData;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence clear_capture_s;
		capFire && clearAfter;
	endsequence

	// A step taken from zero, as after a clearing capture
	sequence first_step_s;
		lowStep && !capFire && cntLow_q == 16'h0000
			&& cmpLow_q != 16'h0000;
	endsequence

	capture_copy_a: assert property (capFire |=>
		capResult_q == $past(cntLow_q))
		else $error("capture result does not match counter");
	clear_after_a: assert property (clear_capture_s |=>
		cntLow_q == 16'h0000)
		else $error("counter not cleared after capture");
	hold_after_a: assert property (
		capFire && !clearAfter && !lowStep |=> $stable(cntLow_q))
		else $error("counter changed on hold capture");
	resume_zero_a: assert property (
		first_step_s |=> cntLow_q == 16'h0001)
		else $error("counter did not resume from zero");
	capture_flag_a: assert property (capFire |=> capFlag_q ##1
		(capFlag_q || $past(stClr[itc_pkg::ST_CAP])))
		else $error("capture flag not held");
	low_wrap_a: assert property (
		lowStep && cntLow_q == cmpLow_q && !capFire |=>
		cntLow_q == 16'h0000)
		else $error("low pair did not wrap at compare");
	match_trig_a: assert property (
		highMatch && trigSel == itc_pkg::TRIG_CMP_HIGH && modeCap
		&& capCtl_q[itc_pkg::CC_EN] |-> capFire ##1 capFlag_q)
		else $error("high pair match did not capture");
	low_stop_a: assert property (
		!ctl_q[itc_pkg::CTL_RUN0] && !capFire |=> $stable(cntLow_q))
		else $error("low pair counted while stopped");
	high_stop_a: assert property (
		!ctl_q[itc_pkg::CTL_RUN2] |=> $stable(cntHigh_q))
		else $error("high pair counted while stopped");
	bus_ack_a: assert property (busReq |=> wbAckO ##1 !wbAckO)
		else $error("ack not a single cycle");
endmodule

// File: bench/itc_osc_model.sv
// Purpose: Behavioural on-chip oscillator feeding one bank of clock pins
// Assumes: Level lengths are whole sys_clk cycles, at least 3 each
// Notes: Only the selected pin toggles; the others stay low, as stopped
`timescale 1ns/10ps
module itc_osc_model #(
	parameter int HALF = 4
) (
	input wire logic sys_clk,
	input wire logic en,
	input wire logic [2:0] sel,
	output logic [7:0] clkOut,
	output int edges
);
	logic lvl;
	int ph;

	initial begin
		lvl = 1'h0;
		ph = 0;
		edges = 0;
	end

	// Level timer; a high level always finishes so no runt pulse escapes
	always @(posedge sys_clk) begin
		if (en || lvl) begin
			if (ph == HALF - 1) begin
				ph <= 0;
				lvl <= !lvl;
				if (!lvl) edges <= edges + 1;
			end else begin
				ph <= ph + 1;
			end
		end
	end

	// Route the level to the selected source only
	always_comb begin
		clkOut = 8'h00;
		clkOut[sel] = lvl;
	end
endmodule

// File: bench/tb_interval_timer_capture16.sv
// Purpose: Self-checking bench for the 16-bit capture timer block
// Assumes: Clock pins come from two oscillator models, count and capture
// Notes: Counts are checked only with both oscillators stopped and settled
`timescale 1ns/10ps
module tb_interval_timer_capture16;
	logic sys_clk, rst, wbCycI, wbStbI, wbWeI, wbAckO, capTrigIn;
	logic cntEn, capture_enable_bit;
	logic [7:0] wbAdrI, countClkIn, capClkIn;
	logic [3:0] wbSelI;
	logic [31:0] wbDatI, wbDatO, rd;
	logic [2:0] cntSel;
	int cntEdges, capEdges, error_cnt, cmp_count;

	itc_capture16 DUT (.sys_clk(sys_clk), .rst(rst), .wbCycI(wbCycI),
		.wbStbI(wbStbI), .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI),
		.wbDatI(wbDatI), .wbDatO(wbDatO), .wbAckO(wbAckO),
		.countClkIn(countClkIn), .capClkIn(capClkIn), .capTrigIn(capTrigIn));
	// Capture oscillator is the slower one, as in calibration use
	itc_osc_model #(.HALF(4)) cntOsc (.sys_clk(sys_clk), .en(cntEn),
		.sel(cntSel), .clkOut(countClkIn), .edges(cntEdges));
	itc_osc_model #(.HALF(6)) capOsc (.sys_clk(sys_clk), .en(capture_enable_bit),
		.sel(3'h2), .clkOut(capClkIn), .edges(capEdges));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Classic single cycle; request held until ack is sampled high
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		wbCycI <= 1'h1;
		wbStbI <= 1'h1;
		wbWeI <= we;
		wbAdrI <= a;
		wbSelI <= 4'hF;
		wbDatI <= d;
		// Ack is registered: look mid-cycle, act at the following edge
		do @(negedge sys_clk); while (wbAckO !== 1'h1);
		@(posedge sys_clk);
		rd = wbDatO;
		wbCycI <= 1'h0;
		wbStbI <= 1'h0;
		wbWeI <= 1'h0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
		input logic [31:0] m = 32'hFFFFFFFF);
		wb(1'h0, a, 32'h00000000);
		chk(rd & m, exp);
	endtask

	// Run one oscillator for n rising edges, then let the pipeline drain
	task automatic osc(input bit c, input int n);
		int s;
		s = c ? capEdges : cntEdges;
		if (c) capture_enable_bit <= 1'h1;
		else cntEn <= 1'h1;
		while ((c ? capEdges : cntEdges) - s < n)
			@(posedge sys_clk);
		capture_enable_bit <= 1'h0;
		cntEn <= 1'h0;
		repeat (20) @(posedge sys_clk);
	endtask

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog and test sequence
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'h0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// Whole run needs about 1000 cycles; generous margin before cutting
	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		stop_test();
	end

	initial begin
		rst = 1'h1;
		{wbCycI, wbStbI, wbWeI, capTrigIn, cntEn, capture_enable_bit} = 6'h00;
		wbAdrI = 8'h00;
		wbSelI = 4'h0;
		wbDatI = 32'h00000000;
		cntSel = 3'h5;
		error_cnt = 0;
		cmp_count = 0;
		repeat (4) @(posedge sys_clk);
		rst <= 1'h0;
		rdchk(itc_pkg::OFF_CMP_LOW, 32'h0000FFFF); // Reset compare
		rdchk(itc_pkg::OFF_CMP_HIGH, 32'h0000FFFF); // Reset compare
		rdchk(itc_pkg::OFF_CTL, 32'h00000000); // Control reset
		rdchk(8'h30, 32'h00000000); // Unmapped place reads zero
		$display("Test done: reset values");
		// Run bit without capture mode must not count; pin 5 is driven while source 0 is still selected
		wb(1'h1, itc_pkg::OFF_CTL, 32'h00000001);
		osc(0, 5);
		rdchk(itc_pkg::OFF_CNT_LOW, 32'h00000000); // Mode off, source unselected
		wb(1'h1, itc_pkg::OFF_CMP_LOW, 32'h00000009);
		rdchk(itc_pkg::OFF_CMP_LOW, 32'h00000009); // Readback
		wb(1'h1, itc_pkg::OFF_CLK_SEL, 32'h00000025);
		rdchk(itc_pkg::OFF_CLK_SEL, 32'h00000025); // Selects
		wb(1'h1, itc_pkg::OFF_CTL, 32'h00000011);
		osc(0, 7);
		rdchk(itc_pkg::OFF_CNT_LOW, 32'h00000007); // Edges
		cntSel = 3'h3;
		osc(0, 4);
		rdchk(itc_pkg::OFF_CNT_LOW, 32'h00000007); // Other source
		cntSel = 3'h5;
		osc(0, 5);
		rdchk(itc_pkg::OFF_CNT_LOW, 32'h00000002); // Wrap at 9
		// Eight ticks at divide-by-2 give four steps from any phase
		wb(1'h1, itc_pkg::OFF_DIV_LOW, 32'h00000001);
		osc(0, 8);
		rdchk(itc_pkg::OFF_CNT_LOW, 32'h00000006); // Divided
		wb(1'h1, itc_pkg::OFF_DIV_LOW, 32'h00000000);
		wb(1'h1, itc_pkg::OFF_CTL, 32'h00000010);
		osc(0, 3);
		rdchk(itc_pkg::OFF_CNT_LOW, 32'h00000006); // Stopped
		$display("Test done: low pair counting");
		// High pair free-runs with no trigger selected
		wb(1'h1, itc_pkg::OFF_CAP_CTL, 32'h00000030);
		wb(1'h1, itc_pkg::OFF_CMP_HIGH, 32'h00000005);
		wb(1'h1, itc_pkg::OFF_CTL, 32'h00000014);
		osc(1, 8);
		rdchk(itc_pkg::OFF_CNT_HIGH, 32'h00000002); // Wrap
		osc(1, 4);
		rdchk(itc_pkg::OFF_CNT_HIGH, 32'h00000000); // Pair count
		rdchk(itc_pkg::OFF_CAP_RES, 32'h00000000); // No trigger
		wb(1'h1, itc_pkg::OFF_CTL, 32'h00000011);
		osc(1, 3);
		rdchk(itc_pkg::OFF_CNT_HIGH, 32'h00000000); // Stopped
		$display("Test done: high pair counting");
		// Match every 2 capture counts, clear after capture
		wb(1'h1, itc_pkg::OFF_CMP_HIGH, 32'h00000001); // Interval
		wb(1'h1, itc_pkg::OFF_CAP_CTL, 32'h00000003);
		wb(1'h1, itc_pkg::OFF_CTL, 32'h00000015);
		osc(0, 3);
		osc(1, 2);
		rdchk(itc_pkg::OFF_CAP_RES, 32'h00000009); // Capture
		rdchk(itc_pkg::OFF_CNT_LOW, 32'h00000000); // Cleared
		rdchk(itc_pkg::OFF_STATUS, 32'h00000001, 32'h00000003);
		osc(0, 4);
		rdchk(itc_pkg::OFF_CNT_LOW, 32'h00000004); // Resumes
		// Software trigger, hold, flag still set gives overrun
		wb(1'h1, itc_pkg::OFF_CAP_CTL, 32'h00000021);
		wb(1'h1, itc_pkg::OFF_SW_TRIG, 32'h00000001);
		rdchk(itc_pkg::OFF_CAP_RES, 32'h00000004); // Soft source
		rdchk(itc_pkg::OFF_CNT_LOW, 32'h00000004); // Held
		rdchk(itc_pkg::OFF_STATUS, 32'h00000003, 32'h00000003);
		wb(1'h1, itc_pkg::OFF_STATUS, 32'h00000003);
		rdchk(itc_pkg::OFF_STATUS, 32'h00000004, 32'h00000007);
		$display("Test done: match and soft capture");
		// Pin trigger with clear
		wb(1'h1, itc_pkg::OFF_CAP_CTL, 32'h00000013);
		osc(0, 2);
		@(posedge sys_clk);
		capTrigIn <= 1'h1;
		repeat (4) @(posedge sys_clk);
		capTrigIn <= 1'h0;
		repeat (10) @(posedge sys_clk);
		rdchk(itc_pkg::OFF_CAP_RES, 32'h00000006); // Pin source
		rdchk(itc_pkg::OFF_CNT_LOW, 32'h00000000); // Cleared
		// Capture disabled: trigger leaves the result alone
		wb(1'h1, itc_pkg::OFF_CAP_CTL, 32'h00000020);
		osc(0, 3);
		wb(1'h1, itc_pkg::OFF_SW_TRIG, 32'h00000001);
		rdchk(itc_pkg::OFF_CAP_RES, 32'h00000006); // Enable gate
		rdchk(itc_pkg::OFF_CNT_LOW, 32'h00000003); // Untouched
		$display("Test done: pin capture and enable");
		stop_test();
	end
endmodule
